// >>> rtl/vic_map.vh
// Register offsets, field positions, reset values and encodings of the interrupt controller.
`ifndef VIC_MAP_VH
`define VIC_MAP_VH
// ********************************************************************
// Register offsets
// ********************************************************************
`define VIC_ADDR_W 4
`define VIC_REG_CTRL0 4'h0
`define VIC_REG_GROUP 4'h1
`define VIC_REG_EDGE 4'h2
`define VIC_REG_PORTD 4'h3
`define VIC_REG_STACK 4'h4
`define VIC_REG_SVC 4'h5
// ********************************************************************
// Control register 0 fields
// ********************************************************************
`define VIC_C0_GIE 0
`define VIC_C0_ENA 1
`define VIC_C0_ENB 2
`define VIC_C0_ENT0 3
`define VIC_C0_ENT1 4
`define VIC_C0_ENSER 5
`define VIC_C0_ENGRP 6
`define VIC_C0_RST 8'h00
// ********************************************************************
// Flag positions in the flag vector and group register
// ********************************************************************
`define VIC_SRC_N 6
`define VIC_F_A 0
`define VIC_F_B 1
`define VIC_F_T0 2
`define VIC_F_T1 3
`define VIC_F_SER 4
`define VIC_F_GRP 5
`define VIC_GRP_N 4
`define VIC_G_ADC 0
`define VIC_G_RTC 1
`define VIC_G_TB 2
`define VIC_G_PER 3
`define VIC_GRP_RST 8'h00
// ********************************************************************
// Edge select encodings, two bits per line
// ********************************************************************
`define VIC_EDGE_OFF 2'h0
`define VIC_EDGE_RISE 2'h1
`define VIC_EDGE_FALL 2'h2
`define VIC_EDGE_BOTH 2'h3
`define VIC_EDGE_RST 8'h00
`define VIC_PORTD_RST 8'h30
`define VIC_PORTD_A 4
`define VIC_PORTD_B 5
// ********************************************************************
// Vectors and stack
// ********************************************************************
`define VIC_VEC_A 8'h04
`define VIC_VEC_B 8'h08
`define VIC_VEC_T0 8'h0C
`define VIC_VEC_T1 8'h10
`define VIC_VEC_SER 8'h14
`define VIC_VEC_GRP 8'h18
`define VIC_PC_W 14
`define VIC_STACK_DEPTH 12
`define VIC_SP_W 4
`define VIC_FILT_LEN 2
`endif

// >>> rtl/vic_vectored_irq.v
// Vectored interrupt controller with return stack and external edge lines.
//
// Contract
// - Enabled flag pushes PC, loads vector
// - Global enable clear blocks all service
// - Service entry clears global enable
// - Blocked requests still set pending flags
// - Full stack defers acknowledge until pop
// - Return instruction pops PC, resumes
// - Requests sampled, serviced on phase-two pulse
// - Fixed priority, vectors 04H through 18H
// - Group sources keep flags, set group
// - Group flag cleared on service
// - External needs global, line, edge set
// - Selected edge sets line flag
// - Pin active only when enabled, input
// - External service clears line flag
// - Pull-high kept while pin interrupts
// - Edge select rise, fall, both, off
// - One option disables all input filters
// - Group needs global, group enable, flag
// - Serial flag set by transfer, cleared
`timescale 1ns/1ps
`include "vic_map.vh"

module vic_vectored_irq #(
   parameter PC_W = `VIC_PC_W,
   parameter DEPTH = `VIC_STACK_DEPTH,
   parameter FILT_LEN = `VIC_FILT_LEN
) (
   // Clock and reset
   input wire core_clk,
   input wire arst_n,
   // Register port
   input wire [`VIC_ADDR_W-1:0] regAddr,
   input wire [7:0] regWrData,
   input wire regWr,
   input wire regRd,
   output reg [7:0] regRdData,
   // Pins and configuration
   input wire extIrqPinA,
   input wire extIrqPinB,
   input wire filterOff,
   input wire [1:0] pullHighSel,
   output reg [1:0] pullHighEn,
   // Event sources, one-cycle pulses
   input wire timer0Ovf,
   input wire timer1Ovf,
   input wire serialDone,
   input wire [`VIC_GRP_N-1:0] groupEvent,
   // Core side
   input wire phaseTwoClock,
   input wire [PC_W-1:0] corePc,
   input wire returnFromIrqInstr,
   input wire callInstr,
   input wire retInstr,
   output reg irqTaken,
   output reg [PC_W-1:0] nextPc,
   output reg pcLoad,
   output reg [`VIC_SP_W-1:0] stackDepth
);

   // ********************************************************************
   // Registers
   // ********************************************************************
   reg [7:0] ctrl0;
   reg [`VIC_SRC_N-1:0] flags;
   reg [`VIC_GRP_N-1:0] grpFlags;
   reg [3:0] grpEnable;
   reg [7:0] edgeSel;
   reg [7:0] portDDir;
   reg [PC_W-1:0] stackMem [0:DEPTH-1];
   reg [`VIC_SP_W-1:0] sp;
   reg [1:0] pinSync;
   reg [1:0] pinPrev;
   reg [FILT_LEN-1:0] filtA;
   reg [FILT_LEN-1:0] filtB;
   reg [1:0] pinClean;

   // ********************************************************************
   // Register decode
   // ********************************************************************
   localparam SEL_CTRL0 = 0;
   localparam SEL_GROUP = 1;
   localparam SEL_EDGE = 2;
   localparam SEL_PORTD = 3;
   localparam SEL_STACK = 4;
   localparam SEL_SVC = 5;

   // One-hot select of the register at an address; unmapped gives zero.
   function [5:0] regSelect;
      input [`VIC_ADDR_W-1:0] addr;
      begin
         regSelect = 6'h00;
         if (addr == `VIC_REG_CTRL0)
            regSelect[SEL_CTRL0] = 1'b1;
         else if (addr == `VIC_REG_GROUP)
            regSelect[SEL_GROUP] = 1'b1;
         else if (addr == `VIC_REG_EDGE)
            regSelect[SEL_EDGE] = 1'b1;
         else if (addr == `VIC_REG_PORTD)
            regSelect[SEL_PORTD] = 1'b1;
         else if (addr == `VIC_REG_STACK)
            regSelect[SEL_STACK] = 1'b1;
         else if (addr == `VIC_REG_SVC)
            regSelect[SEL_SVC] = 1'b1;
      end
   endfunction

   wire [5:0] wrSel = regWr ? regSelect(regAddr) : 6'h00;
   wire [5:0] rdSel = regSelect(regAddr);

   // ********************************************************************
   // Edge detection
   // ********************************************************************
   function edgeHit;
      input [1:0] sel;
      input prev;
      input cur;
      begin
         case (sel)
            `VIC_EDGE_RISE: edgeHit = ~prev & cur;
            `VIC_EDGE_FALL: edgeHit = prev & ~cur;
            `VIC_EDGE_BOTH: edgeHit = prev ^ cur;
            default: edgeHit = 1'b0;
         endcase
      end
   endfunction

   // The filter only accepts a level held for FILT_LEN samples; the one
   // option bypasses both line filters together.
   wire filtAOk = (&filtA) | ~(|filtA);
   wire filtBOk = (&filtB) | ~(|filtB);
   wire [1:0] pinLevel = filterOff ? pinSync :
      {filtBOk ? filtB[0] : pinClean[1], filtAOk ? filtA[0] : pinClean[0]};

   // The pin acts only with line enable and port direction as input.
   wire lineAOn = ctrl0[`VIC_C0_ENA] & portDDir[`VIC_PORTD_A];
   wire lineBOn = ctrl0[`VIC_C0_ENB] & portDDir[`VIC_PORTD_B];
   wire hitA = lineAOn & edgeHit(edgeSel[1:0], pinPrev[0], pinLevel[0]);
   wire hitB = lineBOn & edgeHit(edgeSel[3:2], pinPrev[1], pinLevel[1]);

   // ********************************************************************
   // Arbitration
   // ********************************************************************
   wire [`VIC_SRC_N-1:0] enables = {ctrl0[`VIC_C0_ENGRP],
      ctrl0[`VIC_C0_ENSER], ctrl0[`VIC_C0_ENT1], ctrl0[`VIC_C0_ENT0],
      ctrl0[`VIC_C0_ENB] & (edgeSel[3:2] != `VIC_EDGE_OFF),
      ctrl0[`VIC_C0_ENA] & (edgeSel[1:0] != `VIC_EDGE_OFF)};
   wire [`VIC_SRC_N-1:0] pending = flags & enables;
   wire stackFull = (sp == DEPTH[`VIC_SP_W-1:0]);
   wire canTake = ctrl0[`VIC_C0_GIE] & ~stackFull & phaseTwoClock;

   reg [`VIC_SRC_N-1:0] grant;
   reg [7:0] vector;
   integer i;
   always @* begin
      grant = {`VIC_SRC_N{1'b0}};
      vector = 8'h00;
      for (i = `VIC_SRC_N - 1; i >= 0; i = i - 1) begin
         if (pending[i]) begin
            grant = {`VIC_SRC_N{1'b0}};
            grant[i] = 1'b1;
         end
      end
      if (grant[`VIC_F_A]) vector = `VIC_VEC_A;
      else if (grant[`VIC_F_B]) vector = `VIC_VEC_B;
      else if (grant[`VIC_F_T0]) vector = `VIC_VEC_T0;
      else if (grant[`VIC_F_T1]) vector = `VIC_VEC_T1;
      else if (grant[`VIC_F_SER]) vector = `VIC_VEC_SER;
      else if (grant[`VIC_F_GRP]) vector = `VIC_VEC_GRP;
   end
   wire take = canTake & (|pending);
   wire spEmpty = (sp == {`VIC_SP_W{1'b0}});
   // A pop or call in a service cycle is lost, so the core must not
   // issue one in the same cycle as a phase-two pulse with a request.
   wire doPop = (returnFromIrqInstr | retInstr) & ~spEmpty & ~take;
   wire doCall = callInstr & ~stackFull & ~take;

   // ********************************************************************
   // Flags
   // ********************************************************************
   wire [`VIC_GRP_N-1:0] grpSet = groupEvent;
   wire [`VIC_SRC_N-1:0] setEv = {|(grpSet & grpEnable), serialDone,
      timer1Ovf, timer0Ovf, hitB, hitA};
   wire wrCtrl = wrSel[SEL_CTRL0];
   wire wrSvc = wrSel[SEL_SVC];
   wire wrGrp = wrSel[SEL_GROUP];
   wire wrEdge = wrSel[SEL_EDGE];
   wire wrPortD = wrSel[SEL_PORTD];
   wire [`VIC_SRC_N-1:0] next_flags = setEv |
      (flags & ~(take ? grant : {`VIC_SRC_N{1'b0}}) &
      ~(wrSvc ? ~regWrData[`VIC_SRC_N-1:0] : {`VIC_SRC_N{1'b0}}));

   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl0 <= `VIC_C0_RST;
         flags <= {`VIC_SRC_N{1'b0}};
         grpFlags <= {`VIC_GRP_N{1'b0}};
         grpEnable <= 4'h0;
         edgeSel <= `VIC_EDGE_RST;
         portDDir <= `VIC_PORTD_RST;
      end else begin
         // Events win over clears in the same cycle.
         flags <= next_flags;
         grpFlags <= grpSet | (grpFlags &
            ~(wrGrp ? ~regWrData[3:0] : 4'h0));
         if (wrCtrl)
            ctrl0 <= regWrData;
         if (take)
            ctrl0[`VIC_C0_GIE] <= 1'b0;
         if (wrGrp)
            grpEnable <= regWrData[7:4];
         if (wrEdge)
            edgeSel <= regWrData;
         if (wrPortD)
            portDDir <= regWrData;
      end
   end

   // ********************************************************************
   // Pin sampling and filter
   // ********************************************************************
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pinSync <= 2'h3;
         pinPrev <= 2'h3;
         filtA <= {FILT_LEN{1'b1}};
         filtB <= {FILT_LEN{1'b1}};
         pinClean <= 2'h3;
         pullHighEn <= 2'h0;
      end else begin
         pinSync <= {extIrqPinB, extIrqPinA};
         filtA <= {filtA[FILT_LEN-2:0], pinSync[0]};
         filtB <= {filtB[FILT_LEN-2:0], pinSync[1]};
         pinClean <= pinLevel;
         pinPrev <= pinLevel;
         pullHighEn <= pullHighSel;
      end
   end

   // ********************************************************************
   // Stack and program counter
   // ********************************************************************
   genvar g;
   generate
      for (g = 0; g < DEPTH; g = g + 1) begin : gStack
         always @(posedge core_clk or negedge arst_n) begin
            if (!arst_n)
               stackMem[g] <= {PC_W{1'b0}};
            else if ((take | doCall) && sp == g)
               stackMem[g] <= corePc;
         end
      end
   endgenerate

   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sp <= {`VIC_SP_W{1'b0}};
         irqTaken <= 1'b0;
         pcLoad <= 1'b0;
         nextPc <= {PC_W{1'b0}};
         stackDepth <= {`VIC_SP_W{1'b0}};
      end else begin
         irqTaken <= take;
         pcLoad <= take | doPop;
         if (take) begin
            sp <= sp + 1'b1;
            nextPc <= {{(PC_W-8){1'b0}}, vector};
            stackDepth <= sp + 1'b1;
         end else if (doPop) begin
            sp <= sp - 1'b1;
            nextPc <= stackMem[sp - 1'b1];
            stackDepth <= sp - 1'b1;
         end else if (doCall) begin
            sp <= sp + 1'b1;
            stackDepth <= sp + 1'b1;
         end
      end
   end

   // ********************************************************************
   // Read port
   // ********************************************************************
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n)
         regRdData <= 8'h00;
      else if (regRd) begin
         if (rdSel[SEL_CTRL0])
            regRdData <= ctrl0;
         else if (rdSel[SEL_GROUP])
            regRdData <= {grpEnable, grpFlags};
         else if (rdSel[SEL_EDGE])
            regRdData <= edgeSel;
         else if (rdSel[SEL_PORTD])
            regRdData <= portDDir;
         else if (rdSel[SEL_STACK])
            regRdData <= {{(8-`VIC_SP_W){1'b0}}, sp};
         else if (rdSel[SEL_SVC])
            regRdData <= {2'h0, flags};
         else
            regRdData <= 8'h00;
      end
   end

endmodule

// >>> testbench/vic_irq_props.sv
// Port relation checker for the vectored interrupt controller.
`timescale 1ns/1ps
module vic_irq_props #(
   parameter PC_W = 14
) (
   // Clock and reset
   input wire core_clk,
   input wire arst_n,
   // Observed ports
   input wire phaseTwoClock,
   input wire returnFromIrqInstr,
   input wire [1:0] pullHighSel,
   input wire [1:0] pullHighEn,
   input wire irqTaken,
   input wire pcLoad,
   input wire [PC_W-1:0] nextPc,
   input wire [3:0] stackDepth
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   property p_load; irqTaken |-> pcLoad; endproperty
   a_load: assert property (p_load)
      else $error("service without pc load");
   property p_vec;
      irqTaken |-> nextPc inside {'h04, 'h08, 'h0C, 'h10, 'h14, 'h18};
   endproperty
   a_vec: assert property (p_vec)
      else $error("service vector not in table");
   property p_phase; irqTaken |-> $past(phaseTwoClock); endproperty
   a_phase: assert property (p_phase)
      else $error("service outside phase two");
   property p_push;
      irqTaken |-> stackDepth == $past(stackDepth) + 4'h1;
   endproperty
   a_push: assert property (p_push)
      else $error("service did not push");
   property p_full; stackDepth == 4'hC |=> !irqTaken; endproperty
   a_full: assert property (p_full)
      else $error("service with full stack");
   property p_nest; irqTaken |=> !irqTaken [*3]; endproperty
   a_nest: assert property (p_nest)
      else $error("nested service without enable");
   property p_pop;
      returnFromIrqInstr && stackDepth != 4'h0 |=> pcLoad;
   endproperty
   a_pop: assert property (p_pop)
      else $error("return did not load pc");
   property p_pull;
      $past(arst_n) |-> pullHighEn == $past(pullHighSel);
   endproperty
   a_pull: assert property (p_pull)
      else $error("pull-high selection lost");
endmodule
bind vic_vectored_irq vic_irq_props #(.PC_W(PC_W)) props_u (.core_clk,
   .arst_n, .phaseTwoClock, .returnFromIrqInstr, .pullHighSel,
   .pullHighEn, .irqTaken, .pcLoad, .nextPc, .stackDepth);

// >>> testbench/vic_core_model.sv
// Core stand-in: program counter and phase-two pulse.
`timescale 1ns/1ps
module vic_core_model (
   // Clock and reset
   input wire core_clk,
   input wire arst_n,
   // Controller side
   input wire pcLoad,
   input wire [13:0] nextPc,
   output reg [13:0] corePc,
   output reg phaseTwoClock
);
   reg [1:0] phase;
   // The count stands in for fetch, so each entry saves a new address.
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         corePc <= 14'h0100;
         phase <= 2'h0;
         phaseTwoClock <= 1'b0;
      end else begin
         phase <= phase + 2'h1;
         phaseTwoClock <= (phase == 2'h3);
         corePc <= pcLoad ? nextPc : corePc + 14'h0001;
      end
   end
endmodule

// >>> testbench/tb_vectored_interrupt_control.sv
// Self-checking bench of the vectored interrupt controller.
`timescale 1ns/1ps
`include "vic_map.vh"
module tb_vectored_interrupt_control;
   reg core_clk = 0, arst_n = 0, regWr = 0, regRd = 0;
   reg [3:0] regAddr = 4'h0, groupEvent = 4'h0;
   reg [7:0] regWrData = 8'h00;
   reg extIrqPinA = 0, extIrqPinB = 0, filterOff = 0;
   reg [1:0] pullHighSel = 2'h2;
   reg timer0Ovf = 0, timer1Ovf = 0, serialDone = 0;
   reg returnFromIrqInstr = 0, callInstr = 0, retInstr = 0;
   wire phaseTwoClock, irqTaken, pcLoad;
   wire [13:0] corePc, nextPc;
   wire [7:0] regRdData;
   wire [1:0] pullHighEn;
   wire [3:0] stackDepth;
   integer fails = 0, n_tests = 0, i, k, m, e;
   reg [13:0] lastPc;
   reg [13:0] pcq [$];
   always #2 core_clk = ~core_clk;
   vic_vectored_irq dut_u (.core_clk, .arst_n, .regAddr, .regWrData,
      .regWr, .regRd, .regRdData, .extIrqPinA, .extIrqPinB, .filterOff,
      .pullHighSel, .pullHighEn, .timer0Ovf, .timer1Ovf, .serialDone,
      .groupEvent, .phaseTwoClock, .corePc, .returnFromIrqInstr,
      .callInstr, .retInstr, .irqTaken, .nextPc, .pcLoad, .stackDepth);
   vic_core_model core_u (.core_clk, .arst_n, .pcLoad, .nextPc,
      .corePc, .phaseTwoClock);
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task chk(input [79:0] what, input [15:0] seen, exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            fails = fails + 1;
            $display("MISMATCH %0s exp %h seen %h", what, exp, seen);
         end
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d fails %0d", n_tests, fails);
         if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
         else $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task wr(input [3:0] a, input [7:0] d);
      begin
         @(posedge core_clk);
         regAddr <= a;
         regWrData <= d;
         regWr <= 1'b1;
         @(posedge core_clk);
         regWr <= 1'b0;
      end
   endtask
   task rd(input [3:0] a, input [7:0] exp);
      begin
         @(posedge core_clk);
         regAddr <= a;
         regRd <= 1'b1;
         @(posedge core_clk);
         regRd <= 1'b0;
         #1 chk("regread", regRdData, exp);
      end
   endtask
   task pulse(input [6:0] v);
      begin
         @(posedge core_clk);
         {groupEvent, serialDone, timer1Ovf, timer0Ovf} <= v;
         @(posedge core_clk);
         {groupEvent, serialDone, timer1Ovf, timer0Ovf} <= 7'h00;
      end
   endtask
   // Fixed window: three phase-two pulses pass inside it.
   task quiet;
      begin
         k = 0;
         repeat (12) @(negedge core_clk) k = k + (irqTaken !== 1'b0);
         chk("quiet", k, 0);
      end
   endtask
   task take(input [13:0] vec);
      begin
         i = 0;
         while (irqTaken !== 1'b1 && i < 200) begin
            lastPc = corePc;
            @(negedge core_clk);
            i = i + 1;
         end
         if (irqTaken !== 1'b1) begin
            fails = fails + 1;
            finish_test;
         end else begin
            chk("vector", nextPc, vec);
            pcq.push_back(lastPc);
         end
      end
   endtask
   task ret;
      begin
         @(posedge core_clk);
         returnFromIrqInstr <= 1'b1;
         @(posedge core_clk);
         returnFromIrqInstr <= 1'b0;
         @(negedge core_clk);
         chk("popped", {pcLoad, nextPc}, {1'b1, pcq.pop_back()});
      end
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task s_reset;
      begin
         rd(`VIC_REG_CTRL0, 8'h00);
         rd(`VIC_REG_PORTD, 8'h30);
         rd(4'hF, 8'h00);
         chk("pullhigh", pullHighEn, 2'h2);
      end
   endtask
   task s_blocked;
      begin
         wr(`VIC_REG_CTRL0, 8'h38);
         pulse(7'h17);
         quiet;
         rd(`VIC_REG_SVC, 8'h1C);
         rd(`VIC_REG_GROUP, 8'h02);
         wr(`VIC_REG_GROUP, 8'h11);
         pulse(7'h08);
         rd(`VIC_REG_SVC, 8'h3C);
      end
   endtask
   task s_prio;
      begin
         for (m = 0; m < 4; m = m + 1) begin
            wr(`VIC_REG_CTRL0, 8'h7F);
            take(14'h0C + {m[11:0], 2'h0});
            rd(`VIC_REG_CTRL0, 8'h7E);
         end
         rd(`VIC_REG_SVC, 8'h00);
         rd(`VIC_REG_GROUP, 8'h11);
         wr(`VIC_REG_GROUP, 8'h10);
         repeat (4) ret;
         chk("depth", stackDepth, 4'h0);
      end
   endtask
   task s_edge;
      begin
         wr(`VIC_REG_CTRL0, 8'h02);
         for (m = 1; m < 5; m = m + 1) begin
            wr(`VIC_REG_EDGE, m == 4 ? 8'h03 : m[7:0]);
            wr(`VIC_REG_PORTD, m == 4 ? 8'h20 : 8'h30);
            for (e = 0; e < 2; e = e + 1) begin
               @(posedge core_clk);
               extIrqPinA <= ~extIrqPinA;
               repeat (8) @(posedge core_clk);
               rd(`VIC_REG_SVC, {7'h00, m[e] & m < 4});
               wr(`VIC_REG_SVC, 8'hFE);
            end
         end
         wr(`VIC_REG_PORTD, 8'h30);
         // A filtered edge flags after four edges, a bypassed one after two.
         for (e = 0; e < 2; e = e + 1) begin
            @(posedge core_clk);
            extIrqPinA <= ~extIrqPinA;
            filterOff <= e[0];
            pullHighSel <= 2'h1;
            @(posedge core_clk);
            rd(`VIC_REG_SVC, {7'h00, e[0]});
            repeat (4) @(posedge core_clk);
            rd(`VIC_REG_SVC, 8'h01);
            if (e == 0) wr(`VIC_REG_SVC, 8'hFE);
         end
         chk("pullhigh", pullHighEn, 2'h1);
         wr(`VIC_REG_EDGE, `VIC_EDGE_OFF);
         wr(`VIC_REG_CTRL0, 8'h03);
         quiet;
         wr(`VIC_REG_EDGE, `VIC_EDGE_BOTH);
         take(14'h0004);
         rd(`VIC_REG_SVC, 8'h00);
         ret;
      end
   endtask
   task s_full;
      begin
         repeat (12) begin
            @(posedge core_clk);
            callInstr <= 1'b1;
            @(posedge core_clk);
            callInstr <= 1'b0;
         end
         pulse(7'h01);
         wr(`VIC_REG_CTRL0, 8'h09);
         quiet;
         @(posedge core_clk);
         retInstr <= 1'b1;
         @(posedge core_clk);
         retInstr <= 1'b0;
         take(14'h000C);
      end
   endtask
   initial begin
      repeat (5) @(posedge core_clk);
      arst_n <= 1'b1;
      s_reset;
      s_blocked;
      s_prio;
      s_edge;
      s_full;
      finish_test;
   end
endmodule
